// ---- inc/eac_pkg.sv ----
// Constants, types and register map for the EEPROM access control block.
// Assumes one 250 MHz clock, an APB3 slave port and a synchronous
// calibrated-oscillator tick that paces the programming time.
// Operation
// R01 - Control bits seven and six read zero
// R02 - Mode field picks atomic, erase or write
// R03 - Mode writes ignored while write strobe set
// R04 - Reset clears mode unless programming continues
// R05 - Ready interrupt held while strobe clear
// R06 - Master arm self-clears four cycles later
// R07 - Strobe starts programming only while armed
// R08 - Software waits idle, arms, strobes within four
// R09 - Software checks flash programming finished first; the bench's prog task polls only the strobe bit, not the flash flag
// R10 - Software keeps interrupts off during sequence
// R11 - Hardware clears strobe when time elapses
// R12 - Accepted write strobe stalls CPU two cycles
// R13 - Read strobe fetches byte, stalls four cycles
// R14 - No reads or address change while busy
// R15 - Software polls strobe clear before reading
// R16 - Write timed by 26368 oscillator ticks
// R17 - Address holds nine bits, upper bits zero
// R18 - Data register feeds writes, takes reads
// R19 - Strobe ignored while flash self-programming
package eac_pkg;

  // ---------------------------------------------------------------
  // Register map (byte offsets on APB)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL = 12'h000; // Control register
  localparam logic [11:0] OFF_ADDR = 12'h004; // Nine-bit address
  localparam logic [11:0] OFF_DATA = 12'h008; // Data byte
  localparam logic [11:0] OFF_STAT = 12'h00c; // Status, read only

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CB_READ = 0; // Read strobe
  localparam int CB_STROBE = 1; // Write strobe
  localparam int CB_ARM = 2; // Master write arm
  localparam int CB_IRQEN = 3; // Ready interrupt enable
  localparam int CB_MODE_LO = 4; // Mode field low bit
  localparam int CB_MODE_HI = 5; // Mode field high bit
  localparam int SB_FLASH = 0; // Status: flash flag seen
  localparam int SB_STALL = 1; // Status: CPU stall active
  localparam int ADDR_W = 9; // 512-byte space

  // ---------------------------------------------------------------
  // Programming modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    EAC_MODE_ATOMIC = 2'h0, // Erase then write
    EAC_MODE_ERASE = 2'h1, // Erase only
    EAC_MODE_WRITE = 2'h2, // Write only
    EAC_MODE_RSVD = 2'h3 // Reserved, never starts
  } eac_mode_t;

  // Request to the array; array latches fields on start
  typedef struct packed {
    logic start;
    eac_mode_t mode;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } eac_nvm_req_t;

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam eac_mode_t MODE_RESET = EAC_MODE_ATOMIC;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [2:0] ARM_CYCLES = 3'h4; // Arm lifetime
  localparam logic [2:0] STALL_WRITE = 3'h2; // Stall after strobe
  localparam logic [2:0] STALL_READ = 3'h4; // Stall after read
  localparam int ATOMIC_TIME_US = 3400; // Erase plus write
  localparam int SPLIT_TIME_US = 1800; // Erase or write alone
  localparam int ATOMIC_TICKS = 26368; // Oscillator ticks
  // Split modes scale the atomic tick count by the time ratio
  localparam int SPLIT_TICKS =
    ATOMIC_TICKS * SPLIT_TIME_US / ATOMIC_TIME_US;
  localparam int TICK_W = 15; // Fits 26368

endpackage

// ---- rtl/eac_prog_timer.sv ----
// Programming-time counter paced by the calibrated oscillator tick.
// Assumes the tick is a one-cycle pulse synchronous to i_clock.
`timescale 1ns/1ns
`default_nettype none
module eac_prog_timer
  import eac_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_por_rst,
  input wire logic i_clk_en,
  input wire logic i_start,
  input wire logic [TICK_W-1:0] i_limit,
  input wire logic i_osc_tick,
  output logic o_busy,
  output logic o_done
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    EAC_ST_IDLE = 2'b01, // No programming
    EAC_ST_RUN = 2'b10 // Counting ticks
  } eac_tstate_t;

  eac_tstate_t state_q, state_d; // Timer state
  logic [TICK_W-1:0] cnt_q, cnt_d; // Ticks left
  logic done_q, done_d; // End pulse

  // Next state; only power-on clears, so programming survives i_rst
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    case (state_q)
      EAC_ST_IDLE: begin
        if (i_start) begin
          state_d = EAC_ST_RUN;
          cnt_d = i_limit; // R16
        end
      end
      EAC_ST_RUN: begin
        if (i_osc_tick) begin
          if (cnt_q <= 15'h0001) begin
            state_d = EAC_ST_IDLE; // R11
            cnt_d = 15'h0000;
            done_d = 1'b1;
          end else begin
            cnt_d = cnt_q - 15'h0001;
          end
        end
      end
      default: begin
        state_d = EAC_ST_IDLE;
        cnt_d = 15'h0000;
      end
    endcase
  end

  // Registers
  always_ff @(posedge i_clock) begin
    if (i_por_rst) begin
      state_q <= EAC_ST_IDLE;
      cnt_q <= 15'h0000;
      done_q <= 1'b0;
    end else if (i_clk_en) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign o_busy = (state_q == EAC_ST_RUN);
  assign o_done = done_q;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_por_rst || !i_clk_en);

  load_limit_a: assert property (i_start && !o_busy |=> // R16
    o_busy && cnt_q == $past(i_limit))
    else $error("timer did not load limit");
  end_strobe_a: assert property (o_busy && i_osc_tick && // R11
    cnt_q == 15'h0001 |=> !o_busy && o_done)
    else $error("timer did not end on last tick");

endmodule // eac_prog_timer
`default_nettype wire

// ---- rtl/eac_top.sv ----
// EEPROM access control: control, address and data registers on APB,
// write arming, timed programming, read fetch and CPU stall.
// Assumes a byte array outside that latches o_nvm_req on start and
// returns the byte at o_nvm_req.addr on i_nvm_rdata in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module eac_top
  import eac_pkg::*;
#(
  parameter logic [TICK_W-1:0] P_ATOMIC_TICKS = TICK_W'(ATOMIC_TICKS),
  parameter logic [TICK_W-1:0] P_SPLIT_TICKS = TICK_W'(SPLIT_TICKS)
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_por_rst,
  input wire logic i_clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU side
  input wire logic i_global_irq_en,
  input wire logic i_flash_selfprog_flag,
  output logic o_ready_irq,
  output logic o_cpu_stall,
  // Array side
  input wire logic i_osc_tick,
  input wire logic [7:0] i_nvm_rdata,
  output eac_nvm_req_t o_nvm_req
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Word decode, shared by every register select
  function automatic logic eac_hit(input logic [11:0] a,
                                   input logic [11:0] off);
    eac_hit = (a[11:2] == off[11:2]);
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic acc; // Access phase completing
  logic wr; // Write takes effect
  logic wr_ctrl; // Write to control
  logic wr_addr; // Write to address
  logic wr_data; // Write to data
  logic wr_arm; // Software sets arm
  logic mapped; // Address decodes
  logic busy; // Write strobe bit
  logic accept; // Write strobe taken
  logic rd_go; // Read strobe taken
  logic tm_done; // Programming ended
  eac_mode_t new_mode; // Mode in write data
  logic [TICK_W-1:0] limit; // Ticks for this mode
  eac_mode_t mode_q, mode_d; // Programming mode
  logic irqen_q, irqen_d; // Ready interrupt enable
  logic arm_q, arm_d; // Master write arm
  logic [2:0] arm_cnt_q, arm_cnt_d; // Arm lifetime left
  logic [2:0] stall_q, stall_d; // CPU stall left
  logic [ADDR_W-1:0] addr_q, addr_d; // Address register
  logic [7:0] data_q, data_d; // Data register
  logic start_q, start_d; // Start pulse to array
  logic [31:0] rdata_q, rdata_d; // Read data register
  logic [7:0] ctrl_rd; // Control readback

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // Ready drops while the CPU is stalled or the clock is held
  assign pready = i_clk_en && (stall_q == 3'h0); // R12 R13
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign mapped = eac_hit(paddr, OFF_CTRL) || eac_hit(paddr, OFF_ADDR)
    || eac_hit(paddr, OFF_DATA) || eac_hit(paddr, OFF_STAT);
  // Unmapped words answer with an error, writes are dropped
  assign pslverr = psel && penable && !mapped;
  assign wr_ctrl = wr && eac_hit(paddr, OFF_CTRL);
  assign wr_addr = wr && eac_hit(paddr, OFF_ADDR);
  assign wr_data = wr && eac_hit(paddr, OFF_DATA);
  assign wr_arm = wr_ctrl && pwdata[CB_ARM];
  assign new_mode = eac_mode_t'(pwdata[CB_MODE_HI:CB_MODE_LO]);

  // ---------------------------------------------------------------
  // Strobe acceptance
  // ---------------------------------------------------------------
  // A strobe counts only while armed, idle, flash quiet and mode legal
  assign accept = wr_ctrl && pwdata[CB_STROBE] && arm_q // R07
    && !busy && !i_flash_selfprog_flag // R19
    && new_mode != EAC_MODE_RSVD; // R02
  // Read is refused while programming; a write strobe also wins
  assign rd_go = wr_ctrl && pwdata[CB_READ] && !busy // R14
    && !accept;
  // Atomic takes the full count, split modes the shorter one
  assign limit = (new_mode == EAC_MODE_ATOMIC) ? P_ATOMIC_TICKS // R02
    : P_SPLIT_TICKS;

  // Programming timer, busy is the visible strobe bit
  eac_prog_timer u_timer (
    .i_clock(i_clock),
    .i_por_rst(i_por_rst),
    .i_clk_en(i_clk_en),
    .i_start(accept),
    .i_limit(limit),
    .i_osc_tick(i_osc_tick),
    .o_busy(busy),
    .o_done(tm_done)
  );

  // ---------------------------------------------------------------
  // Control, address and data next state
  // ---------------------------------------------------------------
  // Software writes, hardware timeouts and strobe effects
  always_comb begin
    mode_d = mode_q;
    irqen_d = irqen_q;
    arm_d = arm_q;
    arm_cnt_d = arm_cnt_q;
    stall_d = stall_q;
    addr_d = addr_q;
    data_d = data_q;
    start_d = accept; // One-cycle start to the array
    // Mode frozen while a write runs
    if (wr_ctrl && !busy) begin
      mode_d = new_mode; // R03
    end
    if (wr_ctrl) begin
      irqen_d = pwdata[CB_IRQEN];
    end
    // Arm: software sets, hardware clears; zero writes do nothing
    if (wr_arm) begin
      arm_d = 1'b1;
      arm_cnt_d = ARM_CYCLES - 3'h1; // R06
    end else if (arm_q) begin
      if (arm_cnt_q == 3'h0) begin
        arm_d = 1'b0; // R06
      end else begin
        arm_cnt_d = arm_cnt_q - 3'h1;
      end
    end
    // Stall counter; both strobes never load in one cycle
    if (accept) begin
      stall_d = STALL_WRITE; // R12
    end else if (rd_go) begin
      stall_d = STALL_READ; // R13
    end else if (stall_q != 3'h0) begin
      stall_d = stall_q - 3'h1;
    end
    // Address locked during programming
    if (wr_addr && !busy) begin
      addr_d = pwdata[ADDR_W-1:0]; // R14 R17
    end
    // Read fetch takes priority over a data write (never together)
    if (rd_go) begin
      data_d = i_nvm_rdata; // R13 R18
    end else if (wr_data) begin
      data_d = pwdata[7:0]; // R18
    end
  end

  // Registers; i_rst spares the mode while programming goes on
  always_ff @(posedge i_clock) begin
    if (i_por_rst) begin
      mode_q <= MODE_RESET;
      irqen_q <= 1'b0;
      arm_q <= 1'b0;
      arm_cnt_q <= 3'h0;
      stall_q <= 3'h0;
      addr_q <= ADDR_RESET;
      data_q <= DATA_RESET;
      start_q <= 1'b0;
    end else if (i_rst) begin
      if (!busy) begin
        mode_q <= MODE_RESET; // R04
      end
      irqen_q <= 1'b0;
      arm_q <= 1'b0;
      arm_cnt_q <= 3'h0;
      stall_q <= 3'h0;
      addr_q <= ADDR_RESET;
      data_q <= DATA_RESET;
      start_q <= 1'b0;
    end else if (i_clk_en) begin
      mode_q <= mode_d;
      irqen_q <= irqen_d;
      arm_q <= arm_d;
      arm_cnt_q <= arm_cnt_d;
      stall_q <= stall_d;
      addr_q <= addr_d;
      data_q <= data_d;
      start_q <= start_d;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Read strobe always reads back zero, it acts and is gone
  assign ctrl_rd = {2'h0, mode_q, irqen_q, arm_q, busy, 1'b0}; // R01

  // Registered mux; sampled once per cycle so setup gives the value
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (eac_hit(paddr, OFF_CTRL)) begin
      rdata_d[7:0] = ctrl_rd;
    end else if (eac_hit(paddr, OFF_ADDR)) begin
      rdata_d[ADDR_W-1:0] = addr_q; // R17
    end else if (eac_hit(paddr, OFF_DATA)) begin
      rdata_d[7:0] = data_q;
    end else if (eac_hit(paddr, OFF_STAT)) begin
      rdata_d[SB_FLASH] = i_flash_selfprog_flag;
      rdata_d[SB_STALL] = (stall_q != 3'h0);
    end
  end

  // Read data flop
  always_ff @(posedge i_clock) begin
    if (i_por_rst || i_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_clk_en) begin
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = rdata_q;
  // Level, not a pulse: keeps firing while the array is ready
  assign o_ready_irq = irqen_q && i_global_irq_en && !busy; // R05
  assign o_cpu_stall = (stall_q != 3'h0); // R12 R13
  assign o_nvm_req = '{start: start_q, mode: mode_q,
                       addr: addr_q, wdata: data_q};

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst || i_por_rst || !i_clk_en);

  rsvd_zero_a: assert property ( // R01
    psel && !penable && !pwrite && eac_hit(paddr, OFF_CTRL)
    |=> prdata[7:6] == 2'h0)
    else $error("reserved control bits not zero");
  mode_lock_a: assert property ( // R03
    busy && wr_ctrl |=> mode_q == $past(mode_q))
    else $error("mode changed while busy");
  irq_level_a: assert property ( // R05
    irqen_q && i_global_irq_en |-> o_ready_irq == !ctrl_rd[CB_STROBE])
    else $error("ready interrupt level wrong");
  arm_life_a: assert property ( // R06
    wr_arm |=> arm_q [*4])
    else $error("arm dropped early");
  arm_expire_a: assert property ( // R06
    wr_arm ##1 (!wr_arm) [*4] |=> !arm_q)
    else $error("arm did not expire after four cycles");
  strobe_gate_a: assert property ( // R07
    wr_ctrl && pwdata[CB_STROBE] && !arm_q && !busy |=> !busy)
    else $error("unarmed strobe started programming");
  flash_block_a: assert property ( // R19
    wr_ctrl && i_flash_selfprog_flag && !busy |=> !busy)
    else $error("strobe taken during flash programming");
  write_stall_a: assert property ( // R12
    accept |=> o_cpu_stall [*2] ##1 !o_cpu_stall)
    else $error("write stall not two cycles");
  read_stall_a: assert property ( // R13
    rd_go |=> (data_q == $past(i_nvm_rdata)) ##0 o_cpu_stall [*4]
    ##1 !o_cpu_stall)
    else $error("read fetch or stall wrong");
  addr_lock_a: assert property ( // R14
    busy && wr_addr |=> addr_q == $past(addr_q))
    else $error("address changed while busy");
  start_pulse_a: assert property ( // R07
    accept |=> busy && start_q ##1 !start_q)
    else $error("start not a single pulse");

  write_cov: cover property (accept ##[1:1000] tm_done);
  read_cov: cover property (rd_go ##5 !o_cpu_stall);
  expire_cov: cover property ($fell(arm_q) && !busy);
  irq_cov: cover property ($fell(busy) && o_ready_irq);

endmodule // eac_top
`default_nettype wire

// ---- dv/eac_nvm_model.sv ----
// Byte array and calibrated oscillator model facing the access control.
// Assumes start is a one-cycle pulse with mode, address and data valid.
`timescale 1ns/1ns
`default_nettype none
module eac_nvm_model
  import eac_pkg::*;
#(
  parameter int P_TICK_DIV = 3 // Clocks per oscillator tick
) (
  input wire logic i_clock,
  input wire eac_nvm_req_t i_req,
  output logic [7:0] o_rdata,
  output logic o_tick
);
  // ---------------------------------------------------------------
  // Array state
  // ---------------------------------------------------------------
  logic [7:0] mem [512]; // Byte cells
  int n_start = 0; // Starts seen
  eac_mode_t last_mode = EAC_MODE_RSVD; // Mode of last start
  int div = 0; // Oscillator divider

  // Fetch is combinational from the addressed cell
  assign o_rdata = mem[i_req.addr];
  assign o_tick = (div == 0);

  // Oscillator runs free; ticks are not aligned to any access
  always @(posedge i_clock) begin
    div <= (div == P_TICK_DIV - 1) ? 0 : div + 1;
  end

  // Latch on start; write-only can only clear bits, like a real cell
  always @(posedge i_clock) begin
    if (i_req.start) begin
      n_start <= n_start + 1;
      last_mode <= i_req.mode;
      case (i_req.mode)
        EAC_MODE_ATOMIC: mem[i_req.addr] <= i_req.wdata;
        EAC_MODE_ERASE: mem[i_req.addr] <= 8'hff;
        default: mem[i_req.addr] <= mem[i_req.addr] & i_req.wdata;
      endcase
    end
  end

  // Known contents so a missed write shows up
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = 8'(i) ^ 8'ha5;
    end
  end
endmodule // eac_nvm_model
`default_nettype wire

// ---- dv/eac_top_tb.sv ----
// Self-checking bench for the EEPROM access control over APB.
// Assumes the array model beside it and shortened programming counts.
`timescale 1ns/1ns
`default_nettype none
module eac_top_tb
  import eac_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam int LA = 8; // Atomic ticks, shortened
  localparam int LS = 4; // Split ticks, shortened
  localparam int LIMIT = 20000; // Hang ceiling in cycles
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_por_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic glob = 1'b1; // Global interrupt enable
  logic flash = 1'b0; // Flash self-programming flag
  logic o_ready_irq;
  logic o_cpu_stall;
  logic osc_tick;
  logic [7:0] nvm_rdata;
  eac_nvm_req_t nvm_req;
  logic last_err = 1'b0; // Error flag of last transfer
  int fails = 0;
  int n_compared = 0;
  int stall_n = 0; // Stalled cycles so far
  int low_n = 0; // Cycles with ready interrupt low
  int cyc = 0;

  eac_top #(
    .P_ATOMIC_TICKS(TICK_W'(LA)),
    .P_SPLIT_TICKS(TICK_W'(LS))
  ) u_eac_top (
    .i_clock(i_clock), .i_rst(i_rst), .i_por_rst(i_por_rst),
    .i_clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_global_irq_en(glob),
    .i_flash_selfprog_flag(flash), .o_ready_irq(o_ready_irq),
    .o_cpu_stall(o_cpu_stall), .i_osc_tick(osc_tick),
    .i_nvm_rdata(nvm_rdata), .o_nvm_req(nvm_req)
  );

  eac_nvm_model u_eac_nvm_model (
    .i_clock(i_clock), .i_req(nvm_req), .o_rdata(nvm_rdata),
    .o_tick(osc_tick)
  );

  // Clock, 4 ns period
  initial begin
    forever #2 i_clock = ~i_clock;
  end

  // Cycle counters; deltas are taken, never cleared, to avoid races
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (o_cpu_stall === 1'b1) stall_n <= stall_n + 1;
    if (o_ready_irq === 1'b0) low_n <= low_n + 1;
    if (cyc == LIMIT) begin
      fails++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    if (fails == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready is high at a rising edge
  // No local limit: the cycle ceiling catches a slave that never answers
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge i_clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    @(posedge i_clock);
    while (pready !== 1'b1) begin
      @(posedge i_clock);
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [11:0] a, input string nm,
                    input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(nm, r, e);
  endtask

  // Poll the strobe bit until programming is over
  task automatic wait_idle();
    logic [31:0] r;
    r = 32'h2;
    while (r[1] !== 1'b0) begin
      apb(1'b0, OFF_CTRL, 32'h0, r);
    end
  endtask

  // Software write sequence: idle, address, data, arm, strobe
  task automatic prog(input logic [1:0] m, input logic [8:0] a,
                      input logic [7:0] d);
    wait_idle();
    glob <= 1'b0;
    wr(OFF_ADDR, 32'(a));
    wr(OFF_DATA, 32'(d));
    wr(OFF_CTRL, 32'({m, 4'b1100}));
    wr(OFF_CTRL, 32'({m, 4'b1010}));
    glob <= 1'b1;
  endtask

  task automatic rd_byte(input logic [8:0] a, input logic [7:0] e);
    int t;
    wr(OFF_ADDR, 32'(a));
    t = stall_n;
    wr(OFF_CTRL, 32'h09);
    rd(OFF_DATA, "fetched byte", 32'(e));
    chk("read stall", 32'(stall_n - t), 32'h4);
  endtask

  task automatic rst_pulse();
    @(posedge i_clock);
    i_rst <= 1'b1;
    @(posedge i_clock);
    i_rst <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] expd [3];
    logic [7:0] wd [3];
    logic [31:0] r;
    logic [1:0] md;
    int s, t, b, L;
    expd = '{8'h5a, 8'hff, 8'h3c};
    wd = '{8'h5a, 8'h00, 8'h3c};
    repeat (20) @(posedge i_clock);
    i_rst <= 1'b0;
    i_por_rst <= 1'b0;
    rd(OFF_CTRL, "ctrl reset", 32'h0);
    wr(OFF_ADDR, 32'hffffffff);
    rd(OFF_ADDR, "addr width", 32'h1ff);
    apb(1'b1, 12'h010, 32'h1, r);
    chk("unmapped", 32'(last_err), 32'h1);
    wr(OFF_CTRL, 32'hc8);
    rd(OFF_CTRL, "ctrl rsvd", 32'h08);
    @(negedge i_clock);
    chk("irq idle", 32'(o_ready_irq), 32'h1);
    @(posedge i_clock);
    glob <= 1'b0;
    @(negedge i_clock);
    chk("irq masked", 32'(o_ready_irq), 32'h0);
    @(posedge i_clock);
    glob <= 1'b1;
    // Each mode: start, stall, time, result; lockouts while busy in atomic mode only
    for (int m = 0; m < 3; m++) begin
      s = u_eac_nvm_model.n_start;
      t = stall_n;
      L = (m == 0) ? LA : LS;
      prog(2'(m), 9'h1a5, wd[m]);
      // Count low cycles from the strobe edge, after the masked window
      b = low_n;
      rd(OFF_CTRL, "ctrl busy", 32'({2'(m), 4'b1010}));
      chk("start", 32'(u_eac_nvm_model.n_start - s), 32'h1);
      chk("mode", 32'(u_eac_nvm_model.last_mode), 32'(m));
      chk("write stall", 32'(stall_n - t), 32'h2);
      if (m == 0) begin
        wr(OFF_CTRL, 32'h28);
        wr(OFF_ADDR, 32'h0);
        t = stall_n;
        wr(OFF_CTRL, 32'h09);
        rd(OFF_CTRL, "mode locked", 32'h0a);
        rd(OFF_ADDR, "addr locked", 32'h1a5);
        chk("busy no read", 32'(stall_n - t), 32'h0);
        @(negedge i_clock);
        chk("irq busy", 32'(o_ready_irq), 32'h0);
      end
      wait_idle();
      b = low_n - b;
      chk("busy time", 32'(b >= 3 * L - 3 && b <= 3 * L + 3), 32'h1);
      rd_byte(9'h1a5, expd[m]);
    end
    // Refusals: arm expired, flash busy, reserved mode, never armed
    for (int k = 0; k < 4; k++) begin
      repeat (4) @(posedge i_clock);
      s = u_eac_nvm_model.n_start;
      flash <= (k == 1);
      md = (k == 2) ? 2'b11 : 2'b00;
      if (k != 3) wr(OFF_CTRL, 32'({md, 4'b1100}));
      if (k == 0) rd(OFF_CTRL, "arm set", 32'h0c);
      if (k == 0) repeat (2) @(posedge i_clock);
      wr(OFF_CTRL, 32'({md, 4'b1010}));
      // Arm has expired by the readback in every case, one cycle ahead when the strobe followed the arm
      r = 32'({md, 4'b1000});
      rd(OFF_CTRL, "refused", r);
      chk("no start", 32'(u_eac_nvm_model.n_start - s), 32'h0);
    end
    flash <= 1'b0;
    // Reset while programming keeps mode, reset when idle clears it
    prog(2'b01, 9'h0f0, 8'h00);
    rst_pulse();
    rd(OFF_CTRL, "mode kept", 32'h12);
    wait_idle();
    rst_pulse();
    rd(OFF_CTRL, "mode cleared", 32'h0);
    rd_byte(9'h0f0, 8'hff);
    finish_test();
  end
endmodule // eac_top_tb
`default_nettype wire
